// *** dv/sctc_chk.sv ***
`timescale 1ns/1ps

module sctc_chk #(
	parameter int NUM_CH = 4
) (
	// Clock and reset
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_sys_rst,
	// Configuration
	input  wire sctc_pkg::sctc_ch_cfg_t   i_ch_cfg [NUM_CH],
	input  wire sctc_pkg::sctc_trig_cfg_t i_trig_cfg,
	input  wire logic [31:0]              i_timebase_us,
	// Watched outputs
	input  wire logic [NUM_CH-1:0]        o_coupling_ac,
	input  wire logic [15:0]              o_range_value [NUM_CH],
	input  wire sctc_pkg::sctc_sample_t   o_smp [NUM_CH],
	input  wire logic [NUM_CH-1:0]        o_overrange,
	input  wire logic                     o_capture_active,
	input  wire logic                     o_trig_pulse,
	input  wire logic                     o_capture_done,
	input  wire logic                     o_continuous,
	input  wire logic                     o_armed
);
	import sctc_pkg::*;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);
	logic [NUM_CH-1:0]  cpl;
	logic signed [16:0] mag0;
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			cpl[c] = i_ch_cfg[c].coupling_ac;
		end
	end
	// Magnitude needs 17 bits so the most negative sample cannot wrap
	assign mag0 = o_smp[0].value[15] ? -17'(o_smp[0].value) : 17'(o_smp[0].value);

	AST_COUPLING: assert property (1'b1 |=> o_coupling_ac == $past(cpl))
		else $error("coupling output differs");
	AST_CONT: assert property (1'b1 |=> o_continuous == ($past(i_timebase_us) >= 32'd200000))
		else $error("continuous flag wrong");
	AST_RANGE_FULL: assert property ((!i_ch_cfg[0].auto_range
		&& i_ch_cfg[0].range_mode == SCTC_RANGE_FULL
		&& $stable(i_ch_cfg[0].range_value)) [*3] |-> o_range_value[0] == i_ch_cfg[0].range_value)
		else $error("full scale span wrong");
	// A span too large for the field is pinned at full scale
	AST_RANGE_DIV: assert property ((!i_ch_cfg[0].auto_range
		&& i_ch_cfg[0].range_mode == SCTC_RANGE_PER_DIV && $stable(i_ch_cfg[0].range_value)) [*3]
		|-> o_range_value[0] == ((32'(i_ch_cfg[0].range_value) * 32'd5 > 32'h0000ffff)
		? 16'hffff : 16'(i_ch_cfg[0].range_value * 16'd5)))
		else $error("per division span wrong");
	AST_OVR: assert property ((!i_ch_cfg[0].auto_range && $stable(i_ch_cfg[0])) [*5]
		##0 (o_smp[0].valid && i_ch_cfg[0].enable)
		|-> o_overrange[0] == (mag0 > $signed({1'b0, o_range_value[0]})))
		else $error("overrange flag wrong");
	AST_GATE: assert property (!i_trig_cfg.enable [*5] |-> !o_trig_pulse)
		else $error("trigger while disabled");
	AST_SINGLE: assert property (o_trig_pulse && i_trig_cfg.mode == SCTC_TM_SINGLE
		|-> ##[1:2] (!o_armed && !o_capture_active))
		else $error("single mode did not stop");
	AST_STOP_QUIET: assert property (!o_capture_active && !o_armed && !i_trig_cfg.rearm
		&& i_trig_cfg.mode == SCTC_TM_SINGLE |=> !o_capture_done && !o_trig_pulse)
		else $error("activity while stopped");
	AST_AUTO: assert property (i_trig_cfg.mode == SCTC_TM_AUTO
		&& i_trig_cfg.timeout == 32'd20 && o_armed
		|-> ##[1:30] (o_capture_done || i_trig_cfg.mode != SCTC_TM_AUTO))
		else $error("auto timeout missed");
	AST_NONE: assert property (i_trig_cfg.mode == SCTC_TM_NONE [*3] |-> o_capture_active)
		else $error("free run not capturing");
	CV_TRIG: cover property (o_trig_pulse && i_trig_cfg.mode == SCTC_TM_SINGLE);
	CV_AUTO: cover property (o_capture_done && i_trig_cfg.mode == SCTC_TM_AUTO);
	CV_OVR: cover property (o_overrange[0] && o_smp[0].valid);
endmodule : sctc_chk

bind sctc_top sctc_chk #(.NUM_CH(NUM_CH)) chk (
	.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_ch_cfg(i_ch_cfg),
	.i_trig_cfg(i_trig_cfg), .i_timebase_us(i_timebase_us), .o_coupling_ac(o_coupling_ac),
	.o_range_value(o_range_value), .o_smp(o_smp), .o_overrange(o_overrange),
	.o_capture_active(o_capture_active), .o_trig_pulse(o_trig_pulse),
	.o_capture_done(o_capture_done), .o_continuous(o_continuous), .o_armed(o_armed)
);

// *** dv/sctc_front_end.sv ***
`timescale 1ns/1ps

module sctc_front_end (
	// Clock and reset
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_sys_rst,
	// Analogue levels and conversion strobe
	input  wire logic signed [15:0]   i_level [4],
	input  wire logic                 i_conv,
	// Converter samples
	output sctc_pkg::sctc_sample_t    o_raw [4]
);
	import sctc_pkg::*;
	// Between conversions the bus toggles, so a stale value is never mistaken for data
	always_ff @(posedge i_clk_sys) begin
		for (int c = 0; c < 4; c++) begin
			o_raw[c].valid <= i_conv && !i_sys_rst;
			o_raw[c].value <= i_sys_rst ? 16'h0000 : (i_conv ? i_level[c] : ~o_raw[c].value);
		end
	end
endmodule : sctc_front_end

// *** dv/sctc_top_bench.sv ***
`timescale 1ns/1ps
`include "sctc_defines.svh"

module sctc_top_bench;
	import sctc_pkg::*;
	logic               clk_sys;
	logic               sys_rst;
	logic signed [15:0] level [4];
	logic               conv;
	sctc_sample_t       raw [4];
	sctc_ch_cfg_t       ch_cfg [4];
	sctc_trig_cfg_t     trig_cfg;
	logic [31:0]        timebase_us;
	logic [3:0]         cpl_o;
	logic [3:0]         ovr;
	logic [15:0]        rng [4];
	logic [15:0]        cmax [4];
	sctc_sample_t       smp [4];
	logic               cap_active;
	logic               trig_pulse;
	logic               cap_done;
	logic               continuous;
	logic               armed;
	int                 n_mismatch;
	int                 n_checks;
	int                 n_trig;
	int                 n_done;
	int                 n_cyc;
	int                 t0;
	logic [31:0]        exp_q [$];
	logic [31:0]        exp_e;
	int                 g [12] = '{1, 10, 20, 1000, 10, 100, 100, 1000, 1000, 1000, -1000, 0};
	int                 cm [12] = '{0, 0, 0, 0, 20, 65, 200, 650, 0, 0, 0, 0};
	int                 ov [4][4] = '{'{0, 5, 6, 1}, '{0, 5, -5, 0}, '{1, 2, 10, 0}, '{1, 2, -11, 1}};

	sctc_front_end fe (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_level(level), .i_conv(conv),
		.o_raw(raw));
	sctc_top dut (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_raw(raw), .i_ch_cfg(ch_cfg),
		.i_trig_cfg(trig_cfg), .i_timebase_us(timebase_us), .o_coupling_ac(cpl_o),
		.o_range_value(rng), .o_smp(smp), .o_clamp_max(cmax), .o_overrange(ovr),
		.o_capture_active(cap_active), .o_trig_pulse(trig_pulse), .o_capture_done(cap_done),
		.o_continuous(continuous), .o_armed(armed));

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic idle(input int n);
		conv = 1'b0;
		repeat (n) @(posedge clk_sys);
		#2;
	endtask : idle

	// Strobe stays high between calls so back-to-back samples need no gap
	task automatic send(input logic signed [15:0] v0, input logic signed [15:0] v1,
		input logic [31:0] e);
		level[0] = v0;
		level[1] = v1;
		level[2] = v1;
		level[3] = v1;
		conv = 1'b1;
		exp_q.push_back(e);
		@(posedge clk_sys);
		#2;
	endtask : send

	task automatic expect_trig(input int n);
		idle(8);
		check(n_trig - t0, n);
		t0 = n_trig;
	endtask : expect_trig

	function automatic logic [15:0] expv(input int p, input logic signed [15:0] v);
		if (p == 11) begin
			return 16'(ch_cfg[0].user_gain * v + ch_cfg[0].user_offset);
		end
		return 16'(g[p] * v);
	endfunction : expv

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		n_cyc++;
		if (n_cyc == 6000) begin
			n_mismatch++;
			stop_test();
		end
	end

	always @(negedge clk_sys) begin
		n_trig += int'(trig_pulse === 1'b1);
		n_done += int'(cap_done === 1'b1);
		if (smp[0].valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(32'h1, 32'h0);
			end else begin
				exp_e = exp_q.pop_front();
				check({smp[0].value, smp[1].value}, exp_e);
				check({smp[2].value, smp[3].value}, {2{exp_e[15:0]}});
			end
		end
	end

	initial begin
		logic signed [15:0] v;
		sys_rst = 1'b1;
		conv = 1'b0;
		level = '{default: 16'sh0};
		for (int c = 0; c < 4; c++) begin
			ch_cfg[c] = '0;
			ch_cfg[c].enable = 1'b1;
			ch_cfg[c].range_value = 16'h7fff;
		end
		trig_cfg = '{enable: 1'b0, mode: SCTC_TM_NONE, channel: 2'h1, rising: 1'b1,
			threshold: 16'sh000a, timeout: 32'd20, rearm: 1'b0};
		timebase_us = 32'd1000;
		n_mismatch = 0;
		n_checks = 0;
		n_trig = 0;
		n_done = 0;
		n_cyc = 0;
		void'($urandom(66703));
		idle(4);
		sys_rst = 1'b0;
		idle(2);
		ch_cfg[0].user_gain = 16'($urandom_range(9, 1));
		ch_cfg[0].user_offset = -16'sd7;
		for (int p = 0; p < 12; p++) begin
			ch_cfg[0].probe_sel = 4'(p);
			idle(3);
			for (int k = 0; k < 3; k++) begin
				v = 16'($urandom_range(60)) - 16'sd30;
				send(v, v, {expv(p, v), v});
			end
			idle(6);
			check(cmax[0], cm[p]);
		end
		ch_cfg[0].probe_sel = `SCTC_PRB_X1;
		for (int i = 0; i < 4; i++) begin
			ch_cfg[0].range_mode = sctc_range_mode_t'(ov[i][0]);
			ch_cfg[0].range_value = 16'(ov[i][1]);
			idle(3);
			v = 16'(ov[i][2]);
			send(v, 16'sh0, {v, 16'h0});
			idle(5);
			check(ovr[0], ov[i][3]);
			check(rng[0], ov[i][0] ? ov[i][1] * 5 : ov[i][1]);
		end
		ch_cfg[0].auto_range = 1'b1;
		repeat (4) send(16'sd1000, 16'sh0, {16'd1000, 16'h0});
		idle(6);
		check(rng[0] > 16'h0005, 1);
		ch_cfg[0].auto_range = 1'b0;
		// Cutoff 0x0010 in kHz gives a one-bit shift: each sample halves the gap
		ch_cfg[0].lpf_cutoff = 16'h0010;
		ch_cfg[0].lpf_unit = 2'd1;
		ch_cfg[0].lpf_enable = 1'b1;
		idle(3);
		send(16'sd100, 16'sh0, {16'd550, 16'h0});
		send(16'sd100, 16'sh0, {16'd325, 16'h0});
		idle(6);
		ch_cfg[0].lpf_enable = 1'b0;
		trig_cfg.enable = 1'b1;
		trig_cfg.mode = SCTC_TM_REPEAT;
		idle(3);
		t0 = n_trig;
		send(16'sh0, -16'sd5, {16'h0, -16'sd5});
		send(16'sd50, -16'sd5, {16'd50, -16'sd5});
		expect_trig(0);
		send(16'sh0, 16'sd20, {16'h0, 16'd20});
		expect_trig(1);
		trig_cfg.rising = 1'b0;
		send(16'sh0, -16'sd20, {16'h0, -16'sd20});
		expect_trig(1);
		trig_cfg.enable = 1'b0;
		send(16'sh0, 16'sd20, {16'h0, 16'd20});
		send(16'sh0, -16'sd20, {16'h0, -16'sd20});
		expect_trig(0);
		trig_cfg.enable = 1'b1;
		trig_cfg.rising = 1'b1;
		trig_cfg.threshold = 16'sd100;
		send(16'sh0, 16'sd50, {16'h0, 16'd50});
		send(16'sh0, 16'sd150, {16'h0, 16'd150});
		expect_trig(1);
		trig_cfg.mode = SCTC_TM_SINGLE;
		for (int r = 0; r < 2; r++) begin
			send(16'sh0, -16'sd20, {16'h0, -16'sd20});
			send(16'sh0, 16'sd150, {16'h0, 16'd150});
			expect_trig(1 - r);
			check({armed, cap_active}, 2'b00);
		end
		trig_cfg.rearm = 1'b1;
		idle(3);
		trig_cfg.rearm = 1'b0;
		idle(2);
		check(armed, 1'b1);
		trig_cfg.mode = SCTC_TM_AUTO;
		t0 = n_done;
		idle(100);
		check((n_done - t0) inside {4, 5}, 1);
		trig_cfg.mode = SCTC_TM_REPEAT;
		idle(2);
		t0 = n_done;
		idle(60);
		check(n_done - t0, 0);
		trig_cfg.mode = SCTC_TM_NONE;
		idle(3);
		check(cap_active, 1'b1);
		timebase_us = 32'd200000;
		idle(3);
		check(continuous, 1'b1);
		timebase_us = 32'd199999;
		idle(3);
		check(continuous, 1'b0);
		for (int c = 0; c < 4; c++) begin
			ch_cfg[c].coupling_ac = 1'($urandom);
		end
		idle(3);
		check(cpl_o, {ch_cfg[3].coupling_ac, ch_cfg[2].coupling_ac, ch_cfg[1].coupling_ac,
			ch_cfg[0].coupling_ac});
		idle(10);
		check(exp_q.size(), 0);
		stop_test();
	end
endmodule : sctc_top_bench

// *** verilog/sctc_defines.svh ***
`ifndef SCTC_DEFINES_SVH
`define SCTC_DEFINES_SVH

// Channel and sample geometry
`define SCTC_NUM_CH          4
`define SCTC_SAMPLE_W        16
`define SCTC_DIVISIONS       10
`define SCTC_HALF_DIVS       5
// Probe selector codes
`define SCTC_PRB_X1          4'h0
`define SCTC_PRB_X10         4'h1
`define SCTC_PRB_X20         4'h2
`define SCTC_PRB_X1000       4'h3
`define SCTC_PRB_CLAMP_10MA  4'h4
`define SCTC_PRB_CLAMP_100MA 4'h5
`define SCTC_PRB_CLAMP_200A  4'h6
`define SCTC_PRB_CLAMP_1A    4'h7
`define SCTC_PRB_PLUG_COIL   4'h8
`define SCTC_PRB_IGN         4'h9
`define SCTC_PRB_IGN_INV     4'ha
`define SCTC_PRB_USER        4'hb
// Clamp maximum currents in amperes
`define SCTC_CLAMP_MAX_20A   16'h0014
`define SCTC_CLAMP_MAX_65A   16'h0041
`define SCTC_CLAMP_MAX_200A  16'h00c8
`define SCTC_CLAMP_MAX_650A  16'h028a
// Ignition probe gains
`define SCTC_IGN_GAIN        16'h03e8
`define SCTC_PLUG_COIL_GAIN  16'h03e8
// Auto-range hysteresis: grow when over, shrink when under a quarter span
`define SCTC_AUTO_SHRINK_SH  2
// Slow time-base threshold, in microseconds per division
`define SCTC_SLOW_TB_US      32'd200000
// Reset values
`define SCTC_RST_TIMEOUT     32'd4000000
`define SCTC_RST_RANGE       16'h0005

`endif

// *** verilog/sctc_lowpass.sv ***
`timescale 1ns/1ps
`include "sctc_defines.svh"

module sctc_lowpass (
	// Clock and reset
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_sys_rst,
	// Control
	input  wire logic                   i_enable,
	input  wire logic [15:0]            i_cutoff,
	input  wire logic [1:0]             i_unit,
	// Samples
	input  wire sctc_pkg::sctc_sample_t i_smp,
	output sctc_pkg::sctc_sample_t      o_smp
);
	import sctc_pkg::*;

	typedef struct packed {
		logic signed [31:0] acc;
		sctc_sample_t       out;
	} sctc_lp_state_t;

	sctc_lp_state_t st;
	sctc_lp_state_t next_st;
	logic [4:0]         shift;
	logic signed [31:0] diff;

	// One-pole filter; coarse cutoff steps as a shift keeps it multiplier free
	function automatic logic [4:0] cut_shift(input logic [15:0] c, input logic [1:0] u);
		logic [4:0] s;
		s = 5'd16;
		for (int i = 15; i >= 0; i--) begin
			if (c[i] && s == 5'd16)
				s = 5'(15 - i);
		end
		if (u == 2'd1)
			s = (s > 5'd10) ? s - 5'd10 : 5'd0;
		else if (u == 2'd2)
			s = (s > 5'd20) ? s - 5'd20 : 5'd0;
		return (s > 5'd15) ? 5'd15 : s;
	endfunction : cut_shift

	always_comb begin
		next_st = st;
		shift = cut_shift(i_cutoff, i_unit);
		diff = 32'(i_smp.value) * 32'sd65536 - st.acc;
		next_st.out.valid = i_smp.valid;
		if (!i_enable) begin
			// Seed only from real samples; the bus carries junk between conversions
			if (i_smp.valid)
				next_st.acc = 32'(i_smp.value) * 32'sd65536;
			next_st.out.value = i_smp.value;
		end else if (i_smp.valid) begin
			next_st.acc = st.acc + (diff >>> shift);
			next_st.out.value = next_st.acc[31:16];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_smp = st.out;
endmodule : sctc_lowpass

// *** verilog/sctc_pkg.sv ***
package sctc_pkg;
	typedef enum logic [1:0] {
		SCTC_TM_NONE,
		SCTC_TM_AUTO,
		SCTC_TM_REPEAT,
		SCTC_TM_SINGLE
	} sctc_trig_mode_t;

	typedef enum logic {
		SCTC_RANGE_FULL,
		SCTC_RANGE_PER_DIV
	} sctc_range_mode_t;

	typedef struct packed {
		logic                    enable;
		logic                    auto_range;
		sctc_range_mode_t        range_mode;
		logic [15:0]             range_value;
		logic                    coupling_ac;
		logic [3:0]              probe_sel;
		logic signed [15:0]      user_gain;
		logic signed [15:0]      user_offset;
		logic                    lpf_enable;
		logic [15:0]             lpf_cutoff;
		logic [1:0]              lpf_unit;
	} sctc_ch_cfg_t;

	typedef struct packed {
		logic                    enable;
		sctc_trig_mode_t         mode;
		logic [1:0]              channel;
		logic                    rising;
		logic signed [15:0]      threshold;
		logic [31:0]             timeout;
		logic                    rearm;
	} sctc_trig_cfg_t;

	typedef struct packed {
		logic                    valid;
		logic signed [15:0]      value;
	} sctc_sample_t;
endpackage : sctc_pkg

// *** verilog/sctc_probe_scale.sv ***
`timescale 1ns/1ps
`include "sctc_defines.svh"

module sctc_probe_scale (
	// Clock and reset
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_sys_rst,
	// Sample in
	input  wire sctc_pkg::sctc_sample_t i_raw,
	input  wire logic [3:0]            i_probe_sel,
	input  wire logic signed [15:0]    i_user_gain,
	input  wire logic signed [15:0]    i_user_offset,
	// Sample out
	output logic [15:0]                o_clamp_max,
	output sctc_pkg::sctc_sample_t     o_scaled
);
	import sctc_pkg::*;

	typedef struct packed {
		sctc_sample_t  out;
		logic [15:0]   clamp_max;
	} sctc_ps_state_t;

	sctc_ps_state_t st;
	sctc_ps_state_t next_st;
	logic signed [31:0] prod;
	logic signed [15:0] gain;
	logic signed [15:0] offs;
	logic               negate;

	function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sd32767)
			return 16'sh7fff;
		else if (v < -32'sd32768)
			return 16'sh8000;
		return v[15:0];
	endfunction : sat16

	always_comb begin
		gain = 16'sh0001;
		offs = 16'sh0000;
		negate = 1'b0;
		next_st = st;
		next_st.clamp_max = 16'h0000;
		unique case (i_probe_sel)
			`SCTC_PRB_X1: gain = 16'sh0001;
			`SCTC_PRB_X10: gain = 16'sh000a;
			`SCTC_PRB_X20: gain = 16'sh0014;
			`SCTC_PRB_X1000: gain = 16'sh03e8;
			// Clamp gains expressed in mA per mV; output unit is mA
			`SCTC_PRB_CLAMP_10MA: begin
				gain = 16'sh000a;
				next_st.clamp_max = `SCTC_CLAMP_MAX_20A;
			end
			`SCTC_PRB_CLAMP_100MA: begin
				gain = 16'sh0064;
				next_st.clamp_max = `SCTC_CLAMP_MAX_65A;
			end
			`SCTC_PRB_CLAMP_200A: begin
				gain = 16'sh0064;
				next_st.clamp_max = `SCTC_CLAMP_MAX_200A;
			end
			`SCTC_PRB_CLAMP_1A: begin
				gain = 16'sh03e8;
				next_st.clamp_max = `SCTC_CLAMP_MAX_650A;
			end
			`SCTC_PRB_PLUG_COIL: gain = `SCTC_PLUG_COIL_GAIN;
			`SCTC_PRB_IGN: gain = `SCTC_IGN_GAIN;
			`SCTC_PRB_IGN_INV: begin
				gain = `SCTC_IGN_GAIN;
				negate = 1'b1;
			end
			`SCTC_PRB_USER: begin
				gain = i_user_gain;
				offs = i_user_offset;
			end
			// Unused codes fall back to unity scaling
			default: gain = 16'sh0001;
		endcase
		prod = gain * i_raw.value + 32'(offs);
		if (negate)
			prod = -prod;
		next_st.out.valid = i_raw.valid;
		next_st.out.value = sat16(prod);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_scaled = st.out;
	assign o_clamp_max = st.clamp_max;
endmodule : sctc_probe_scale

// *** verilog/sctc_top.sv ***
// Function
// - Flag a channel overrange when its conditioned sample exceeds the range.
// - Auto ranging picks vertical scale itself; time base stays untouched.
// - The vertical span maps onto ten divisions; a per-division span too large for the field is pinned at 0xffff.
// - Full-scale mode: setting N spans minus N to plus N.
// - Per-division mode: setting D spans minus five D to plus five D.
// - Each channel selects AC or DC input coupling.
// - Each channel's probe scaling follows its probe_sel setting; reset loads no probe selection.
// - Attenuator probes multiply samples by ten, twenty or one thousand.
// - Clamp probes convert at fixed ratios, each with its own maximum current.
// - The inverted ignition probe negates polarity on top of its scaling.
// - User probes apply gain times input plus offset.
// - Each channel has its own enabled low-pass filter with programmable cutoff.
// - No-trigger mode captures continuously.
// - Auto mode waits for a trigger, then captures anyway after timeout.
// - Repeat mode captures only on triggers and re-arms after each.
// - Single mode stops after the first captured trigger until re-armed.
// - Only the selected trigger channel is evaluated.
// - Edge trigger fires on upward or downward threshold crossing.
// - The trigger threshold level is programmable.
// - Slow time base only raises the continuous flag; capture and triggering are unchanged.
// - Four independent channels, each with its own settings.
`timescale 1ns/1ps
`include "sctc_defines.svh"

module sctc_top #(
	parameter int NUM_CH = `SCTC_NUM_CH
) (
	// Clock and reset
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_sys_rst,
	// Converter samples, one per channel
	input  wire sctc_pkg::sctc_sample_t i_raw [NUM_CH],
	// Channel configuration
	input  wire sctc_pkg::sctc_ch_cfg_t i_ch_cfg [NUM_CH],
	// Trigger and time base configuration
	input  wire sctc_pkg::sctc_trig_cfg_t i_trig_cfg,
	input  wire logic [31:0]            i_timebase_us,
	// Front end controls
	output logic [NUM_CH-1:0]           o_coupling_ac,
	output logic [15:0]                 o_range_value [NUM_CH],
	// Conditioned samples toward the capture buffer
	output sctc_pkg::sctc_sample_t      o_smp [NUM_CH],
	output logic [15:0]                 o_clamp_max [NUM_CH],
	// Status
	output logic [NUM_CH-1:0]           o_overrange,
	output logic                        o_capture_active,
	output logic                        o_trig_pulse,
	output logic                        o_capture_done,
	output logic                        o_continuous,
	output logic                        o_armed
);
	import sctc_pkg::*;

	typedef enum logic [1:0] {
		SCTC_ST_IDLE,
		SCTC_ST_WAIT,
		SCTC_ST_STOPPED
	} sctc_state_t;

	typedef struct packed {
		sctc_state_t        fsm;
		logic [31:0]        timer;
		logic               prev_above;
		logic               prev_valid;
		logic               trig_pulse;
		logic               done;
		logic               capture;
		logic               continuous;
		logic [NUM_CH-1:0]  over;
		logic [NUM_CH-1:0]  coupling;
		logic [NUM_CH*16-1:0] range;
		logic [NUM_CH*16-1:0] auto_range;
		logic [NUM_CH*16-1:0] cmax;
		logic [NUM_CH*17-1:0] smp;
		logic               armed;
	} sctc_top_state_t;

	sctc_top_state_t st;
	sctc_top_state_t next_st;
	sctc_sample_t    scaled [NUM_CH];
	sctc_sample_t    filt [NUM_CH];
	logic [15:0]     clamp_max [NUM_CH];

	// Half span in volts for both range modes; both map onto ten divisions
	function automatic logic [15:0] half_span(input sctc_range_mode_t m, input logic [15:0] v);
		logic [18:0] w;
		w = 19'(v);
		if (m == SCTC_RANGE_PER_DIV)
			w = 19'(v) * 19'(`SCTC_HALF_DIVS);
		return (w > 19'h0ffff) ? 16'hffff : w[15:0];
	endfunction : half_span

	function automatic logic [15:0] mag16(input logic signed [15:0] v);
		return v[15] ? 16'(-v) : 16'(v);
	endfunction : mag16

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		sctc_probe_scale u_scale (
			.i_clk_sys     (i_clk_sys),
			.i_sys_rst     (i_sys_rst),
			.i_raw         (i_raw[c]),
			.i_probe_sel   (i_ch_cfg[c].probe_sel),
			.i_user_gain   (i_ch_cfg[c].user_gain),
			.i_user_offset (i_ch_cfg[c].user_offset),
			.o_clamp_max   (clamp_max[c]),
			.o_scaled      (scaled[c])
		);
		sctc_lowpass u_lpf (
			.i_clk_sys (i_clk_sys),
			.i_sys_rst (i_sys_rst),
			.i_enable  (i_ch_cfg[c].lpf_enable),
			.i_cutoff  (i_ch_cfg[c].lpf_cutoff),
			.i_unit    (i_ch_cfg[c].lpf_unit),
			.i_smp     (scaled[c]),
			.o_smp     (filt[c])
		);
	end

	always_comb begin
		logic [15:0]        span;
		logic [15:0]        cur;
		logic [15:0]        mag;
		logic               fire;
		logic               above;
		logic               chan_valid;
		logic signed [15:0] tv;
		span = 16'h0000;
		cur = 16'h0000;
		mag = 16'h0000;
		fire = 1'b0;
		above = 1'b0;
		chan_valid = 1'b0;
		tv = 16'sh0000;
		next_st = st;
		next_st.trig_pulse = 1'b0;
		next_st.done = 1'b0;

		for (int c = 0; c < NUM_CH; c++) begin
			next_st.coupling[c] = i_ch_cfg[c].coupling_ac;
			next_st.smp[c*17 +: 17] = filt[c];
			next_st.cmax[c*16 +: 16] = clamp_max[c];
			mag = mag16(filt[c].value);
			cur = st.auto_range[c*16 +: 16];
			if (i_ch_cfg[c].auto_range) begin
				// Doubling or halving keeps the search short; the time base is not touched
				if (filt[c].valid && mag > cur && cur < 16'h8000)
					cur = {cur[14:0], 1'b1};
				else if (filt[c].valid && (mag < (cur >> `SCTC_AUTO_SHRINK_SH)) && cur > 16'h0001)
					cur = cur >> 1;
				span = cur;
			end else begin
				span = half_span(i_ch_cfg[c].range_mode, i_ch_cfg[c].range_value);
			end
			next_st.auto_range[c*16 +: 16] = cur;
			next_st.range[c*16 +: 16] = span;
			if (filt[c].valid)
				next_st.over[c] = i_ch_cfg[c].enable && (mag > span);
		end

		// Only the selected channel feeds the comparator
		tv = filt[i_trig_cfg.channel].value;
		chan_valid = filt[i_trig_cfg.channel].valid;
		above = tv > i_trig_cfg.threshold;
		if (chan_valid) begin
			next_st.prev_above = above;
			next_st.prev_valid = 1'b1;
			fire = i_trig_cfg.enable && st.prev_valid &&
				(i_trig_cfg.rising ? (above && !st.prev_above)
					: (!above && st.prev_above));
		end

		next_st.continuous = i_timebase_us >= `SCTC_SLOW_TB_US;

		unique case (st.fsm)
			SCTC_ST_IDLE: begin
				next_st.timer = 32'h0;
				next_st.capture = 1'b1;
				if (i_trig_cfg.mode != SCTC_TM_NONE)
					next_st.fsm = SCTC_ST_WAIT;
			end
			SCTC_ST_WAIT: begin
				unique case (i_trig_cfg.mode)
					SCTC_TM_NONE: begin
						next_st.capture = 1'b1;
						next_st.fsm = SCTC_ST_IDLE;
					end
					SCTC_TM_AUTO: begin
						next_st.capture = 1'b1;
						next_st.timer = st.timer + 32'h1;
						if (fire) begin
							next_st.trig_pulse = 1'b1;
							next_st.done = 1'b1;
							next_st.timer = 32'h0;
						end else if (st.timer >= i_trig_cfg.timeout) begin
							next_st.done = 1'b1;
							next_st.timer = 32'h0;
						end
					end
					SCTC_TM_REPEAT: begin
						// Data is held back unless a trigger actually lands
						next_st.capture = fire;
						next_st.trig_pulse = fire;
						next_st.done = fire;
					end
					SCTC_TM_SINGLE: begin
						next_st.capture = 1'b0;
						if (fire) begin
							next_st.capture = 1'b1;
							next_st.trig_pulse = 1'b1;
							next_st.done = 1'b1;
							next_st.fsm = SCTC_ST_STOPPED;
						end
					end
				endcase
			end
			SCTC_ST_STOPPED: begin
				next_st.capture = 1'b0;
				if (i_trig_cfg.rearm || i_trig_cfg.mode != SCTC_TM_SINGLE)
					next_st.fsm = SCTC_ST_WAIT;
			end
			default: next_st.fsm = SCTC_ST_IDLE;
		endcase
		// Registered so the status pin is not a decode of the state word
		next_st.armed = (next_st.fsm == SCTC_ST_WAIT);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st <= '0;
			st.fsm <= SCTC_ST_IDLE;
			for (int c = 0; c < NUM_CH; c++)
				st.auto_range[c*16 +: 16] <= `SCTC_RST_RANGE;
		end else begin
			st <= next_st;
		end
	end

	assign o_coupling_ac = st.coupling;
	assign o_overrange = st.over;
	assign o_capture_active = st.capture;
	assign o_trig_pulse = st.trig_pulse;
	assign o_capture_done = st.done;
	assign o_continuous = st.continuous;
	assign o_armed = st.armed;
	for (genvar c = 0; c < NUM_CH; c++) begin : g_out
		assign o_range_value[c] = st.range[c*16 +: 16];
		assign o_clamp_max[c] = st.cmax[c*16 +: 16];
		assign o_smp[c] = st.smp[c*17 +: 17];
	end
endmodule : sctc_top
